// file: hw/nfcfe_regs.svh
`ifndef NFCFE_REGS_SVH
`define NFCFE_REGS_SVH

// Register indices; byte address is four times the index
`define NFCFE_IDX_STATUS     8'h24
`define NFCFE_IDX_CONV       8'h25
`define NFCFE_IDX_TUNE_A     8'h26
`define NFCFE_IDX_TUNE_B     8'h27
`define NFCFE_IDX_TXDRV      8'h28

// Reset values
`define NFCFE_RST_TUNE       8'h80
`define NFCFE_RST_TXDRV      8'h70

// Field positions
`define NFCFE_RATE_HI        5
`define NFCFE_RATE_LO        4
`define NFCFE_MOD_HI         7
`define NFCFE_MOD_LO         4
`define NFCFE_RES_HI         3
`define NFCFE_RES_LO         0

`define NFCFE_RES_HIGHZ      4'hf
`define NFCFE_RD_UNMAPPED    32'h0000_0000

`endif

// file: hw/nfcfe_pkg.sv
`default_nettype none

package nfcfe_pkg;

    typedef struct packed {
        logic [1:0] rate;
        logic       second_power_timer_running;
        logic       gp_timer_running;
        logic       no_resp_timer_running;
        logic       mask_rx_timer_running;
    } nfcfe_status_t;

    typedef struct packed {
        logic [3:0] modulation_depth_sel;
        logic [3:0] driver_res_sel;
    } nfcfe_txdrv_t;

    typedef enum logic [1:0] {
        NFCFE_IDLE,
        NFCFE_ANSWER
    } nfcfe_bus_state_t;

endpackage

`default_nettype wire

// file: hw/nfcfe_regbank.sv
// Notes on behaviour
// R1 - Status bits 5:4 show the detected bit rate result.
// R2 - Status bits 3..0 show second power, general, no-response, mask timers running.
// R3 - Conversion register shows the last conversion result completed since reset; resets to 0.
// R4 - First tuning code is writable, eight bits, resets to 0x80.
// R5 - Second tuning code is writable, eight bits, resets to 0x80.
// R6 - Driver bits 7:4 select modulation depth, reset 0111.
// R7 - Driver bits 3:0 select resistance, reset 0, code 15 is high impedance.
// R8 - Status and conversion are read-only; tuning and driver are read-write.
// R9 - Writes to read-only registers are ignored; status bits 7:6 read zero.
`include "nfcfe_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module nfcfe_regbank (
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 resetn,
    // Avalon-MM slave
    input  wire logic [9:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    // Internal state inputs
    input  wire nfcfe_pkg::nfcfe_status_t status_in,
    input  wire logic [7:0]           conversion_data,
    input  wire logic                 conversion_done,
    // Analog control outputs
    output logic      [7:0]           tuning_code_first,
    output logic      [7:0]           tuning_code_second,
    output var nfcfe_pkg::nfcfe_txdrv_t tx_driver,
    output logic                      antenna_driver_output_highz
);
    import nfcfe_pkg::*;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    nfcfe_bus_state_t bus_state_reg;
    nfcfe_status_t    status_reg;
    logic [7:0]       conv_reg;
    logic [7:0]       tune_a_reg;
    logic [7:0]       tune_b_reg;
    logic [7:0]       txdrv_reg;
    logic [7:0]       idx;
    logic             wr_lane0;
    logic             wr_tune_a;
    logic             wr_tune_b;
    logic             wr_txdrv;
    logic             rd_take;
    logic [31:0]      rd_next;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    // Writes commit on the answer edge, where the master sees waitrequest low
    assign idx       = avs_address[9:2];
    assign wr_lane0  = avs_write && avs_byteenable[0] && bus_state_reg == NFCFE_ANSWER;
    assign wr_tune_a = wr_lane0 && idx == `NFCFE_IDX_TUNE_A;
    assign wr_tune_b = wr_lane0 && idx == `NFCFE_IDX_TUNE_B;
    assign wr_txdrv  = wr_lane0 && idx == `NFCFE_IDX_TXDRV;
    assign rd_take   = avs_read && bus_state_reg == NFCFE_IDLE;

    // ----------------------------------------------------------------
    // Bus handshake: one wait cycle, answer on the second edge
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bus_state_reg   <= NFCFE_IDLE;
            avs_waitrequest <= 1'b1;
        end else begin
            case (bus_state_reg)
                NFCFE_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_state_reg   <= NFCFE_ANSWER;
                        avs_waitrequest <= 1'b0;
                    end
                end
                NFCFE_ANSWER: begin
                    bus_state_reg   <= NFCFE_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default: begin
                    bus_state_reg   <= NFCFE_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    a_wait_idle: assert property (@(posedge clock) disable iff (!resetn) // R8
        bus_state_reg == NFCFE_IDLE |-> avs_waitrequest)
        else $error("waitrequest low while idle");

    a_wait_pulse: assert property (@(posedge clock) disable iff (!resetn) // R8
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");

    a_answer_next: assert property (@(posedge clock) disable iff (!resetn) // R8
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered on the next edge");

    a_idle_return: assert property (@(posedge clock) disable iff (!resetn) // R8
        bus_state_reg == NFCFE_ANSWER |=> bus_state_reg == NFCFE_IDLE)
        else $error("bus did not return to idle");

    a_wait_reset: assert property (@(posedge clock) // R8
        $rose(resetn) |-> avs_waitrequest && avs_readdata == `NFCFE_RD_UNMAPPED)
        else $error("bus outputs wrong after reset");

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    always_comb begin
        rd_next = `NFCFE_RD_UNMAPPED;
        case (idx)
            `NFCFE_IDX_STATUS: rd_next = {24'h000000, 2'b00, status_reg}; // R1 R2 R9
            `NFCFE_IDX_CONV:   rd_next = {24'h000000, conv_reg}; // R3
            `NFCFE_IDX_TUNE_A: rd_next = {24'h000000, tune_a_reg}; // R8
            `NFCFE_IDX_TUNE_B: rd_next = {24'h000000, tune_b_reg}; // R8
            `NFCFE_IDX_TXDRV:  rd_next = {24'h000000, txdrv_reg}; // R8
            default:           rd_next = `NFCFE_RD_UNMAPPED;
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_take) begin
            avs_readdata <= rd_next;
        end
    end

    a_status_rsvd: assert property (@(posedge clock) disable iff (!resetn) // R1 R9
        avs_read && bus_state_reg == NFCFE_IDLE && idx == `NFCFE_IDX_STATUS
        |=> avs_readdata[7:6] == 2'b00
            && avs_readdata[`NFCFE_RATE_HI:`NFCFE_RATE_LO] == $past(status_reg.rate))
        else $error("status readback wrong");

    a_conv_read: assert property (@(posedge clock) disable iff (!resetn) // R3
        avs_read && bus_state_reg == NFCFE_IDLE && idx == `NFCFE_IDX_CONV
        |=> avs_readdata[7:0] == $past(conv_reg))
        else $error("conversion readback wrong");

    a_unmapped_zero: assert property (@(posedge clock) disable iff (!resetn) // R8
        avs_read && bus_state_reg == NFCFE_IDLE
            && (idx < `NFCFE_IDX_STATUS || idx > `NFCFE_IDX_TXDRV)
        |=> avs_readdata == `NFCFE_RD_UNMAPPED)
        else $error("unmapped read not zero");

    a_read_upper: assert property (@(posedge clock) disable iff (!resetn) // R8
        !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");

    a_read_hold: assert property (@(posedge clock) disable iff (!resetn) // R8
        !(avs_read && bus_state_reg == NFCFE_IDLE) |=> $stable(avs_readdata))
        else $error("read data changed without a read");

    // ----------------------------------------------------------------
    // Read-only state capture
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            status_reg <= '0;
        end else begin
            status_reg <= status_in; // R1 R2
        end
    end

    a_status_track: assert property (@(posedge clock) disable iff (!resetn) // R2
        resetn |=> status_reg == $past(status_in))
        else $error("status does not follow timers");

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            conv_reg <= 8'h00;
        end else if (conversion_done) begin
            conv_reg <= conversion_data; // R3
        end
    end

    a_conv_capture: assert property (@(posedge clock) disable iff (!resetn) // R3
        resetn && conversion_done |=> conv_reg == $past(conversion_data))
        else $error("conversion result not captured");

    a_conv_hold: assert property (@(posedge clock) disable iff (!resetn) // R3
        !conversion_done |=> $stable(conv_reg))
        else $error("conversion result changed without a conversion");

    a_ro_ignored: assert property (@(posedge clock) disable iff (!resetn) // R9
        avs_write && idx == `NFCFE_IDX_CONV && !conversion_done |=> $stable(conv_reg))
        else $error("write changed read-only register");

    // ----------------------------------------------------------------
    // Writable registers; writes to read-only indices fall through
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tune_a_reg <= `NFCFE_RST_TUNE; // R4
        end else if (wr_tune_a) begin
            tune_a_reg <= avs_writedata[7:0]; // R4 R8
        end
    end

    a_tune_a_reset: assert property (@(posedge clock) // R4
        $rose(resetn) |-> tune_a_reg == `NFCFE_RST_TUNE)
        else $error("first tuning code wrong after reset");

    a_rw_write: assert property (@(posedge clock) disable iff (!resetn) // R4 R8
        avs_write && avs_byteenable[0] && !avs_waitrequest && idx == `NFCFE_IDX_TUNE_A
        |=> tune_a_reg == $past(avs_writedata[7:0]))
        else $error("tuning write not stored");

    a_tune_a_hold: assert property (@(posedge clock) disable iff (!resetn) // R4
        !wr_tune_a |=> $stable(tune_a_reg))
        else $error("first tuning code changed without a write");

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tune_b_reg <= `NFCFE_RST_TUNE; // R5
        end else if (wr_tune_b) begin
            tune_b_reg <= avs_writedata[7:0]; // R5 R8
        end
    end

    a_tune_b_reset: assert property (@(posedge clock) // R5
        $rose(resetn) |-> tune_b_reg == `NFCFE_RST_TUNE)
        else $error("second tuning code wrong after reset");

    a_tune_b_write: assert property (@(posedge clock) disable iff (!resetn) // R5 R8
        avs_write && avs_byteenable[0] && !avs_waitrequest && idx == `NFCFE_IDX_TUNE_B
        |=> tune_b_reg == $past(avs_writedata[7:0]))
        else $error("second tuning write not stored");

    a_tune_b_hold: assert property (@(posedge clock) disable iff (!resetn) // R5
        !wr_tune_b |=> $stable(tune_b_reg))
        else $error("second tuning code changed without a write");

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            txdrv_reg <= `NFCFE_RST_TXDRV; // R6 R7
        end else if (wr_txdrv) begin
            txdrv_reg <= avs_writedata[7:0]; // R6 R7 R8
        end
    end

    a_txdrv_reset: assert property (@(posedge clock) // R6 R7
        $rose(resetn) |-> txdrv_reg == `NFCFE_RST_TXDRV)
        else $error("driver register wrong after reset");

    a_txdrv_write: assert property (@(posedge clock) disable iff (!resetn) // R6 R7 R8
        avs_write && avs_byteenable[0] && !avs_waitrequest && idx == `NFCFE_IDX_TXDRV
        |=> txdrv_reg == $past(avs_writedata[7:0]))
        else $error("driver write not stored");

    a_txdrv_hold: assert property (@(posedge clock) disable iff (!resetn) // R6 R7
        !wr_txdrv |=> $stable(txdrv_reg))
        else $error("driver register changed without a write");

    a_lane_gate: assert property (@(posedge clock) disable iff (!resetn) // R8
        avs_write && !avs_byteenable[0]
        |=> $stable(tune_a_reg) && $stable(tune_b_reg) && $stable(txdrv_reg))
        else $error("write without lane 0 changed a register");

    // ----------------------------------------------------------------
    // Outputs to the analog side
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tuning_code_first           <= `NFCFE_RST_TUNE;
            tuning_code_second          <= `NFCFE_RST_TUNE;
            tx_driver                   <= `NFCFE_RST_TXDRV;
            antenna_driver_output_highz <= 1'b0;
        end else begin
            tuning_code_first  <= tune_a_reg; // R4
            tuning_code_second <= tune_b_reg; // R5
            tx_driver.modulation_depth_sel <= txdrv_reg[`NFCFE_MOD_HI:`NFCFE_MOD_LO]; // R6
            tx_driver.driver_res_sel <= txdrv_reg[`NFCFE_RES_HI:`NFCFE_RES_LO]; // R7
            antenna_driver_output_highz <=
                txdrv_reg[`NFCFE_RES_HI:`NFCFE_RES_LO] == `NFCFE_RES_HIGHZ; // R7
        end
    end

    a_highz_follow: assert property (@(posedge clock) disable iff (!resetn) // R7
        txdrv_reg[`NFCFE_RES_HI:`NFCFE_RES_LO] == `NFCFE_RES_HIGHZ
        |=> antenna_driver_output_highz)
        else $error("code 15 did not give high impedance");

    a_highz_clear: assert property (@(posedge clock) disable iff (!resetn) // R7
        txdrv_reg[`NFCFE_RES_HI:`NFCFE_RES_LO] != `NFCFE_RES_HIGHZ
        |=> !antenna_driver_output_highz)
        else $error("high impedance without code 15");

    a_out_reset: assert property (@(posedge clock) // R4 R5 R6
        $rose(resetn) |-> tuning_code_first == `NFCFE_RST_TUNE
            && tuning_code_second == `NFCFE_RST_TUNE && tx_driver == `NFCFE_RST_TXDRV)
        else $error("analog outputs wrong after reset");

    a_highz_reset: assert property (@(posedge clock) // R7
        $rose(resetn) |-> !antenna_driver_output_highz)
        else $error("high impedance set after reset");

    a_tune_out: assert property (@(posedge clock) disable iff (!resetn) // R4 R5
        resetn |=> tuning_code_first == $past(tune_a_reg)
            && tuning_code_second == $past(tune_b_reg))
        else $error("tuning outputs do not follow registers");

    a_drv_out: assert property (@(posedge clock) disable iff (!resetn) // R6 R7
        resetn |=> tx_driver == $past(txdrv_reg))
        else $error("driver output does not follow register");

endmodule

`default_nettype wire

// file: bench/test_nfcfe_regbank.sv
`timescale 1ns/1ps
`default_nettype none

module test_nfcfe_regbank;
    import nfcfe_pkg::*;

    logic          clock = 1'b0;
    logic          resetn = 1'b0;
    logic [9:0]    avs_address = 10'h000;
    logic          avs_read = 1'b0;
    logic          avs_write = 1'b0;
    logic [31:0]   avs_writedata = 32'h0000_0000;
    logic [3:0]    avs_byteenable = 4'h0;
    logic [31:0]   avs_readdata;
    logic          avs_waitrequest;
    nfcfe_status_t status_in = 6'h00;
    logic [7:0]    conversion_data = 8'h00;
    logic          conversion_done = 1'b0;
    logic [7:0]    tuning_code_first;
    logic [7:0]    tuning_code_second;
    nfcfe_txdrv_t  tx_driver;
    logic          antenna_driver_output_highz;
    int            fails = 0;
    int            compares = 0;
    logic [31:0]   rd;

    nfcfe_regbank dut (
        .clock(clock), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .status_in(status_in), .conversion_data(conversion_data),
        .conversion_done(conversion_done),
        .tuning_code_first(tuning_code_first), .tuning_code_second(tuning_code_second),
        .tx_driver(tx_driver), .antenna_driver_output_highz(antenna_driver_output_highz)
    );

    always #50 clock = ~clock;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One Avalon-MM transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       input logic [3:0] be);
        int n;
        @(posedge clock);
        avs_address <= {idx, 2'b00};
        avs_read <= ~wr;
        avs_write <= wr;
        avs_writedata <= {24'h000000, wd};
        avs_byteenable <= be;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            check({31'h0, avs_waitrequest}, 32'h0);
            stop_test();
        end else begin
            rd = avs_readdata;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
        end
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00, 4'hf);
        check(rd, {24'h000000, exp});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd_chk(8'h26, 8'h80);
        rd_chk(8'h27, 8'h80);
        rd_chk(8'h28, 8'h70);
        check({8'h0, tuning_code_first, tuning_code_second, tx_driver}, 32'h0080_8070);
        check({31'h0, antenna_driver_output_highz}, 32'h0);
    endtask

    task automatic t_status();
        status_in <= 6'h2a;
        rd_chk(8'h24, 8'h2a);
        status_in <= 6'h15;
        bus(1'b1, 8'h24, 8'hff, 4'hf);
        rd_chk(8'h24, 8'h15);
        status_in <= 6'h3f;
        rd_chk(8'h24, 8'h3f);
    endtask

    task automatic t_conv();
        @(posedge clock);
        conversion_data <= 8'h5a;
        conversion_done <= 1'b1;
        @(posedge clock);
        conversion_done <= 1'b0;
        conversion_data <= 8'ha5;
        rd_chk(8'h25, 8'h5a);
        bus(1'b1, 8'h25, 8'h11, 4'hf);
        rd_chk(8'h25, 8'h5a);
    endtask

    task automatic t_tuning();
        bus(1'b1, 8'h26, 8'h00, 4'hf);
        bus(1'b1, 8'h27, 8'hff, 4'hf);
        rd_chk(8'h26, 8'h00);
        rd_chk(8'h27, 8'hff);
        check({16'h0, tuning_code_first, tuning_code_second}, 32'h0000_00ff);
        bus(1'b1, 8'h26, 8'h3c, 4'he);
        rd_chk(8'h26, 8'h00);
        rd_chk(8'h30, 8'h00);
    endtask

    task automatic t_txdrv();
        logic [7:0] codes [3];
        codes = '{8'h0f, 8'hf0, 8'h7e};
        foreach (codes[i]) begin
            bus(1'b1, 8'h28, codes[i], 4'h1);
            rd_chk(8'h28, codes[i]);
            check({24'h0, tx_driver}, {24'h0, codes[i]});
            check({31'h0, antenna_driver_output_highz}, {31'h0, codes[i][3:0] == 4'hf});
        end
    endtask

    // Reset in mid-run brings tuning, driver and conversion registers back to default; status follows its input
    task automatic t_rerun();
        @(posedge clock);
        resetn <= 1'b0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        t_reset();
        rd_chk(8'h25, 8'h00);
        rd_chk(8'h24, 8'h3f);
    endtask

    initial begin
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        t_reset();
        t_status();
        t_conv();
        t_tuning();
        t_txdrv();
        t_rerun();
        stop_test();
    end
endmodule

`default_nettype wire
